// File: src/dla_pkg.sv
// Package for the dual loop alarm evaluator: register map, reset values, mode codes, carriers.
// Assumes a 32-bit classic Wishbone slave port with byte addresses and one aligned word per register.
package dla_pkg;

  localparam int DLA_AW = 8;

  // Register byte addresses
  localparam logic [7:0] DLA_ADR_MODE    = 8'h00;
  localparam logic [7:0] DLA_ADR_HYST0   = 8'h04;
  localparam logic [7:0] DLA_ADR_THR0    = 8'h14;
  localparam logic [7:0] DLA_ADR_SP0     = 8'h24;
  localparam logic [7:0] DLA_ADR_COMP0   = 8'h2C;
  localparam logic [7:0] DLA_ADR_CTRL    = 8'h34;
  localparam logic [7:0] DLA_ADR_STATUS  = 8'h38;
  localparam logic [7:0] DLA_ADR_ACTMODE = 8'h3C;
  localparam logic [7:0] DLA_ADR_STEP    = 8'h04;

  // Control word fields
  localparam int DLA_CTRL_OFF0    = 0;
  localparam int DLA_CTRL_RESTART = 8;

  // Status word fields
  localparam int DLA_STAT_ALARM   = 0;
  localparam int DLA_STAT_STANDBY = 4;

  // Reset values; hysteresis counts tenths of an engineering unit
  localparam logic [15:0] DLA_MODE_RST = 16'h0000;
  localparam logic [15:0] DLA_HYST_RST = 16'h0002;
  localparam logic [15:0] DLA_WORD_RST = 16'h0000;

  typedef enum logic [3:0] {
    DLA_MD_NONE     = 4'h0,
    DLA_MD_DEV_BOTH = 4'h1,
    DLA_MD_DEV_HI   = 4'h2,
    DLA_MD_DEV_LO   = 4'h3,
    DLA_MD_RANGE    = 4'h4,
    DLA_MD_SB_BOTH  = 4'h5,
    DLA_MD_SB_HI    = 4'h6,
    DLA_MD_SB_LO    = 4'h7,
    DLA_MD_ABS_HI   = 4'h8,
    DLA_MD_ABS_LO   = 4'h9,
    DLA_MD_DISABLE  = 4'hF
  } dla_mode_t;

  // Process value samples from the acquisition logic, one lane per loop
  typedef struct packed {
    logic [1:0]       valid;
    logic [1:0][15:0] value;
  } dla_pv_t;

  // Whole state of the evaluator
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic [15:0]      mode_cfg;
    logic [15:0]      mode_act;
    logic [3:0][15:0] hyst_cfg;
    logic [3:0][15:0] hyst_act;
    logic [3:0][15:0] thr;
    logic [1:0][15:0] sp;
    logic [1:0][15:0] comp;
    logic [1:0]       out_off;
    logic [3:0]       alarm;
    logic [3:0]       standby;
  } dla_state_t;

endpackage

// File: src/dla_alarm_eval.sv
// Dual loop alarm evaluator: two alarms per loop, ten modes, hysteresis and standby sequence.
// Assumes a classic Wishbone master on the same clock and process value samples from same-clock logic.
//
// Function
// - Two alarms per loop, mode codes 0-9
// - New mode applies only after restart
// - Mode 0 holds output off; resets 0
// - Mode 1 negative set value: always on
// - Mode 4 negative set value: always off
// - Mode 5 deviation with standby; negative off
// - Modes 6, 7 limit alarms with standby
// - Modes 8, 9 compare absolute level
// - Output turns off after hysteresis margin
// - Own hysteresis per alarm, default 0.2
// - New hysteresis applies only after restart
// - Standby holds off until leaving range
// - Standby low alarm waits rise then fall
// - Standby re-armed at start of operation
// - Set value, compensation, set point rearm
// - Output-off flag falling edge rearms standby
// - Signed 16-bit set value, writable anytime
// - Both modes F disable loop alarms
`timescale 1ns/1ns
module dla_alarm_eval
  import dla_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                cyc,
  input  wire logic                stb,
  input  wire logic                we,
  input  wire logic [DLA_AW-1:0]   adr,
  input  wire logic [3:0]          sel,
  input  wire logic [31:0]         dat_w,
  output logic      [31:0]         dat_r,
  output logic                     ack,
  input  wire dla_pv_t             pv_sample,
  output logic      [3:0]          alarm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  dla_state_t s_r;
  dla_state_t s_nxt;

  logic [3:0] on_c;
  logic [3:0] off_c;
  logic [3:0] forced;
  logic [3:0] forced_val;
  logic [3:0] uses_sb;
  logic [3:0] sample;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic signed [17:0] sx(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-alarm comparison

  genvar a;
  generate
    for (a = 0; a < 4; a++) begin : g_alm
      localparam int L = a / 2;
      logic [3:0]         md;
      logic               loop_off;
      logic signed [17:0] pv;
      logic signed [17:0] sp;
      logic signed [17:0] sv;
      logic signed [17:0] h;
      logic signed [17:0] hi;
      logic signed [17:0] lo;
      logic               neg;

      // Loop 1 alarm 1 sits in the top nibble
      assign md       = s_r.mode_act[(3 - a) * 4 +: 4];
      assign loop_off = (s_r.mode_act[(3 - 2 * L) * 4 +: 4] == DLA_MD_DISABLE) &&
                        (s_r.mode_act[(2 - 2 * L) * 4 +: 4] == DLA_MD_DISABLE);
      assign pv       = sx(pv_sample.value[L]);
      assign sp       = sx(s_r.sp[L]);
      assign sv       = sx(s_r.thr[a]);
      assign h        = {2'b00, s_r.hyst_act[a]};
      assign hi       = sp + sv;
      assign lo       = sp - sv;
      assign neg      = s_r.thr[a][15];
      assign sample[a] = pv_sample.valid[L];

      always_comb begin
        on_c[a]       = 1'b0;
        off_c[a]      = 1'b1;
        forced[a]     = 1'b0;
        forced_val[a] = 1'b0;
        uses_sb[a]    = 1'b0;
        if (loop_off) begin
          forced[a] = 1'b1;
        end else begin
          case (md)
            DLA_MD_DEV_BOTH, DLA_MD_SB_BOTH: begin
              uses_sb[a] = (md == DLA_MD_SB_BOTH);
              if (neg) begin
                forced[a]     = 1'b1;
                forced_val[a] = (md == DLA_MD_DEV_BOTH);
              end else begin
                on_c[a]  = (pv > hi) || (pv < lo);
                off_c[a] = (pv <= hi - h) && (pv >= lo + h);
              end
            end
            DLA_MD_DEV_HI, DLA_MD_SB_HI: begin
              uses_sb[a] = (md == DLA_MD_SB_HI);
              on_c[a]    = pv > hi;
              off_c[a]   = pv <= hi - h;
            end
            DLA_MD_DEV_LO, DLA_MD_SB_LO: begin
              uses_sb[a] = (md == DLA_MD_SB_LO);
              on_c[a]    = pv < lo;
              off_c[a]   = pv >= lo + h;
            end
            DLA_MD_RANGE: begin
              if (neg) begin
                forced[a] = 1'b1;
              end else begin
                on_c[a]  = (pv <= hi) && (pv >= lo);
                off_c[a] = (pv > hi + h) || (pv < lo - h);
              end
            end
            DLA_MD_ABS_HI: begin
              on_c[a]  = pv > sv;
              off_c[a] = pv <= sv - h;
            end
            DLA_MD_ABS_LO: begin
              on_c[a]  = pv < sv;
              off_c[a] = pv >= sv + h;
            end
            default: begin
              forced[a] = 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, restart, standby and alarm outputs

  always_comb begin
    logic        acc;
    logic        wr;
    logic        restart;
    logic [15:0] nv;
    logic [3:0]  rearm;
    s_nxt   = s_r;
    acc     = cyc && stb && !s_r.ack;
    wr      = acc && we;
    restart = 1'b0;
    nv      = DLA_WORD_RST;
    rearm   = 4'h0;
    // Ack drops the cycle after it is given, so each access takes two cycles
    s_nxt.ack = acc;

    if (acc && !we) begin
      s_nxt.rdata = 32'h0000_0000;
      if (adr == DLA_ADR_MODE) begin
        s_nxt.rdata[15:0] = s_r.mode_cfg;
      end else if (adr >= DLA_ADR_HYST0 && adr < DLA_ADR_THR0) begin
        s_nxt.rdata[15:0] = s_r.hyst_cfg[adr[3:2] - 2'd1];
      end else if (adr >= DLA_ADR_THR0 && adr < DLA_ADR_SP0) begin
        s_nxt.rdata[15:0] = s_r.thr[adr[3:2] - 2'd1];
      end else if (adr == DLA_ADR_SP0 || adr == DLA_ADR_SP0 + DLA_ADR_STEP) begin
        s_nxt.rdata[15:0] = s_r.sp[adr[3]];
      end else if (adr == DLA_ADR_COMP0 || adr == DLA_ADR_COMP0 + DLA_ADR_STEP) begin
        s_nxt.rdata[15:0] = s_r.comp[adr[4]];
      end else if (adr == DLA_ADR_CTRL) begin
        s_nxt.rdata[DLA_CTRL_OFF0 +: 2] = s_r.out_off;
      end else if (adr == DLA_ADR_STATUS) begin
        s_nxt.rdata[DLA_STAT_ALARM +: 4]   = s_r.alarm;
        s_nxt.rdata[DLA_STAT_STANDBY +: 4] = s_r.standby;
      end else if (adr == DLA_ADR_ACTMODE) begin
        s_nxt.rdata[15:0] = s_r.mode_act;
      end
    end

    if (wr) begin
      if (adr == DLA_ADR_MODE) begin
        // Only the stored copy changes; evaluation keeps the latched mode
        s_nxt.mode_cfg = merge16(s_r.mode_cfg, dat_w, sel);
      end else if (adr >= DLA_ADR_HYST0 && adr < DLA_ADR_THR0) begin
        s_nxt.hyst_cfg[adr[3:2] - 2'd1] = merge16(s_r.hyst_cfg[adr[3:2] - 2'd1], dat_w, sel);
      end else if (adr >= DLA_ADR_THR0 && adr < DLA_ADR_SP0) begin
        nv = merge16(s_r.thr[adr[3:2] - 2'd1], dat_w, sel);
        s_nxt.thr[adr[3:2] - 2'd1] = nv;
        if (nv != s_r.thr[adr[3:2] - 2'd1]) begin
          rearm[adr[3:2] - 2'd1] = 1'b1;
        end
      end else if (adr == DLA_ADR_SP0 || adr == DLA_ADR_SP0 + DLA_ADR_STEP) begin
        nv = merge16(s_r.sp[adr[3]], dat_w, sel);
        s_nxt.sp[adr[3]] = nv;
        if (nv != s_r.sp[adr[3]]) begin
          rearm[2 * adr[3] +: 2] = 2'b11;
        end
      end else if (adr == DLA_ADR_COMP0 || adr == DLA_ADR_COMP0 + DLA_ADR_STEP) begin
        nv = merge16(s_r.comp[adr[4]], dat_w, sel);
        s_nxt.comp[adr[4]] = nv;
        if (nv != s_r.comp[adr[4]]) begin
          rearm[2 * adr[4] +: 2] = 2'b11;
        end
      end else if (adr == DLA_ADR_CTRL) begin
        if (sel[0]) begin
          s_nxt.out_off = dat_w[DLA_CTRL_OFF0 +: 2];
        end
        if (sel[1]) begin
          restart = dat_w[DLA_CTRL_RESTART];
        end
      end
    end

    // Output-off flag going from on to off
    for (int l = 0; l < 2; l++) begin
      if (s_r.out_off[l] && !s_nxt.out_off[l]) begin
        rearm[2 * l +: 2] = 2'b11;
      end
    end

    // Alarm evaluation on each new sample of the alarm's loop
    for (int i = 0; i < 4; i++) begin
      if (sample[i]) begin
        if (forced[i]) begin
          s_nxt.alarm[i] = forced_val[i];
        end else if (uses_sb[i] && s_r.standby[i]) begin
          // Held off until the value is seen outside the alarm range
          s_nxt.alarm[i] = 1'b0;
          if (!on_c[i]) begin
            s_nxt.standby[i] = 1'b0;
          end
        end else if (!s_r.alarm[i] && on_c[i]) begin
          s_nxt.alarm[i] = 1'b1;
        end else if (s_r.alarm[i] && off_c[i]) begin
          s_nxt.alarm[i] = 1'b0;
        end
      end
      // Re-arm wins over a clear in the same cycle
      if (rearm[i]) begin
        s_nxt.standby[i] = 1'b1;
      end
    end

    // Controller restart: latch configuration and start over
    if (restart) begin
      s_nxt.mode_act = s_r.mode_cfg;
      s_nxt.hyst_act = s_r.hyst_cfg;
      s_nxt.standby  = 4'hF;
      s_nxt.alarm    = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ack      <= 1'b0;
      s_r.rdata    <= 32'h0000_0000;
      s_r.mode_cfg <= DLA_MODE_RST;
      s_r.mode_act <= DLA_MODE_RST;
      s_r.hyst_cfg <= {4{DLA_HYST_RST}};
      s_r.hyst_act <= {4{DLA_HYST_RST}};
      s_r.thr      <= {4{DLA_WORD_RST}};
      s_r.sp       <= {2{DLA_WORD_RST}};
      s_r.comp     <= {2{DLA_WORD_RST}};
      s_r.out_off  <= 2'b00;
      s_r.alarm    <= 4'h0;
      s_r.standby  <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_r     = s_r.rdata;
  assign ack       = s_r.ack;
  assign alarm_out = s_r.alarm;

endmodule

// File: bench/dla_host.sv
// Host controller model: classic Wishbone master that writes and reads settings.
// Assumes one clock shared with the evaluator; the bench calls xfer and pack.
`timescale 1ns/1ns
module dla_host
  import dla_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         ack,
  input  wire logic [31:0]  dat_r,
  output logic              cyc,
  output logic              stb,
  output logic              we,
  output logic [DLA_AW-1:0] adr,
  output logic [3:0]        sel,
  output logic [31:0]       dat_w
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Loop 1 alarm 1 sits in the top nibble
  function automatic logic [15:0] pack(input logic [3:0] a, b, c, d);
    return {a, b, c, d};
  endfunction
  // Request held until ack is seen; waits only end through the bench timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat_w <= {16'h0000, d};
    do @(posedge clock); while (ack !== 1'b1);
    q = dat_r[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule

// File: bench/dla_chk.sv
// Checker for the alarm evaluator ports: bus handshake and alarm update causes.
// Assumes the evaluator's own port names; bound at the foot of this file.
`timescale 1ns/1ns
module dla_chk
  import dla_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              cyc,
  input wire logic              stb,
  input wire logic              we,
  input wire logic [DLA_AW-1:0] adr,
  input wire logic [3:0]        sel,
  input wire logic [31:0]       dat_w,
  input wire logic [31:0]       dat_r,
  input wire logic              ack,
  input wire dla_pv_t           pv_sample,
  input wire logic [3:0]        alarm_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr;
  assign wr = cyc && stb && we;
  ////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack held");
  a_ack_answer: assert property (cyc && stb && !ack |=> ack) else $error("no ack");
  a_ack_cause: assert property (ack |-> $past(cyc && stb)) else $error("stray ack");
  a_upper_zero: assert property (ack && !we |-> dat_r[31:16] == 16'h0000)
    else $error("upper read bits set");
  // Alarms move only on a sample of their loop or a register write
  a_loop1_hold: assert property (!$stable(alarm_out[1:0]) |-> $past(pv_sample.valid[0] || wr))
    else $error("loop 1 alarm moved");
  a_loop2_hold: assert property (!$stable(alarm_out[3:2]) |-> $past(pv_sample.valid[1] || wr))
    else $error("loop 2 alarm moved");
  a_status_match: assert property (ack && !we && adr == DLA_ADR_STATUS && !$past(|pv_sample.valid)
    |-> dat_r[3:0] == alarm_out) else $error("status differs");
  a_restart_clear: assert property (ack && we && adr == DLA_ADR_CTRL && sel[1] && dat_w[DLA_CTRL_RESTART]
    && !$past(|pv_sample.valid) |-> alarm_out == 4'h0) else $error("restart kept alarm");
endmodule
bind dla_alarm_eval dla_chk dla_chk_inst (
  .clock(clock), .rst_n(rst_n), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
  .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .pv_sample(pv_sample), .alarm_out(alarm_out)
);

// File: bench/dla_alarm_eval_tb_top.sv
// Testbench for the alarm evaluator: mode table, restart latching, standby re-arm.
// Assumes the host model drives the bus; samples are driven here on loop lanes.
`timescale 1ns/1ns
module dla_alarm_eval_tb_top
  import dla_pkg::*;
;
  typedef struct packed {
    logic [3:0]       m;
    logic [15:0]      x;
    logic [2:0][15:0] p;
    logic [2:0]       e;
  } dla_row_t;
  localparam dla_row_t ROWS [13] = '{
    '{4'h0, 16'h000A, {16'h0014, 16'hFFEC, 16'h0000}, 3'h0},
    '{4'h1, 16'h000A, {16'h0014, 16'h0000, 16'hFFEC}, 3'h5},
    '{4'h2, 16'h000A, {16'h0014, 16'h0009, 16'h0008}, 3'h6},
    '{4'h3, 16'h000A, {16'hFFEC, 16'hFFF7, 16'h0000}, 3'h6},
    '{4'h4, 16'h000A, {16'h0000, 16'h0014, 16'h0009}, 3'h5},
    '{4'h5, 16'h000A, {16'h0014, 16'h0000, 16'h0014}, 3'h1},
    '{4'h6, 16'h000A, {16'h0014, 16'h0000, 16'h0014}, 3'h1},
    '{4'h7, 16'h000A, {16'hFFEC, 16'h0014, 16'hFFEC}, 3'h1},
    '{4'h8, 16'h000A, {16'h0014, 16'h0009, 16'h0008}, 3'h6},
    '{4'h9, 16'h000A, {16'h0000, 16'h000B, 16'h000C}, 3'h6},
    '{4'h1, 16'hFFFB, {16'h0000, 16'h0000, 16'h0000}, 3'h7},
    '{4'h4, 16'hFFFB, {16'h0000, 16'h0000, 16'h0000}, 3'h0},
    '{4'h5, 16'hFFFB, {16'h0000, 16'h0014, 16'h0000}, 3'h0}};
  logic        clock;
  logic        rst_n;
  dla_pv_t     pv;
  wire         cyc, stb, we, ack;
  wire [7:0]   adr;
  wire [3:0]   sel, alarm_out;
  wire [31:0]  dat_w, dat_r;
  int          error_cnt, comparisons;
  logic [15:0] prev;
  dla_row_t    r;
  dla_host dla_host_inst (.clock(clock), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dat_w));
  dla_alarm_eval dla_alarm_eval_inst (.clock(clock), .rst_n(rst_n), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .pv_sample(pv), .alarm_out(alarm_out));
  initial clock = 1'b0;
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    dla_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] x);
    logic [15:0] q;
    dla_host_inst.xfer(1'b0, a, 16'h0000, q);
    check(x, q);
  endtask
  // One sample on lane b/2, then the alarm bit b a cycle after it is taken
  task automatic sc(input int b, input logic [15:0] v, input logic e);
    @(posedge clock);
    pv.valid[b/2] <= 1'b1;
    pv.value[b/2] <= v;
    @(posedge clock);
    pv.valid <= 2'h0;
    @(posedge clock);
    check({15'h0, e}, {15'h0, alarm_out[b]});
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    pv = '0;
    prev = 16'h0000;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rc(DLA_ADR_MODE, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rc(DLA_ADR_HYST0 + 8'(4 * k), 16'h0002);
    end
    rc(DLA_ADR_STATUS, 16'h00F0);
    wr(DLA_ADR_STATUS, 16'hFFFF);
    rc(DLA_ADR_STATUS, 16'h00F0);
    rc(8'h40, 16'h0000);
    foreach (ROWS[n]) begin
      r = ROWS[n];
      wr(DLA_ADR_THR0, r.x);
      wr(DLA_ADR_MODE, dla_host_inst.pack(r.m, 4'h0, 4'h0, 4'h0));
      rc(DLA_ADR_ACTMODE, prev);
      wr(DLA_ADR_CTRL, 16'h0100);
      prev = dla_host_inst.pack(r.m, 4'h0, 4'h0, 4'h0);
      rc(DLA_ADR_ACTMODE, prev);
      for (int i = 0; i < 3; i++) begin
        sc(0, r.p[2 - i], r.e[2 - i]);
      end
    end
    // New hysteresis waits for a restart
    wr(DLA_ADR_THR0, 16'h000A);
    wr(DLA_ADR_MODE, 16'h8000);
    wr(DLA_ADR_CTRL, 16'h0100);
    wr(DLA_ADR_HYST0, 16'h000A);
    rc(DLA_ADR_HYST0, 16'h000A);
    sc(0, 16'h0014, 1'b1);
    sc(0, 16'h0008, 1'b0);
    wr(DLA_ADR_CTRL, 16'h0100);
    sc(0, 16'h0014, 1'b1);
    sc(0, 16'h0008, 1'b1);
    sc(0, 16'h0000, 1'b0);
    // Standby re-arm by set point, output-off release and compensation
    wr(DLA_ADR_MODE, 16'h6000);
    wr(DLA_ADR_CTRL, 16'h0100);
    sc(0, 16'h0000, 1'b0);
    sc(0, 16'h0014, 1'b1);
    wr(DLA_ADR_SP0, 16'h0005);
    sc(0, 16'h0014, 1'b0);
    sc(0, 16'h0000, 1'b0);
    sc(0, 16'h0014, 1'b1);
    wr(DLA_ADR_CTRL, 16'h0001);
    wr(DLA_ADR_CTRL, 16'h0000);
    sc(0, 16'h0014, 1'b0);
    sc(0, 16'h0000, 1'b0);
    wr(DLA_ADR_COMP0, 16'h0003);
    sc(0, 16'h0014, 1'b0);
    // Both loop 1 codes F silence that loop only
    wr(8'h1C, 16'h000A);
    wr(DLA_ADR_MODE, dla_host_inst.pack(4'hF, 4'hF, 4'h8, 4'h0));
    wr(DLA_ADR_CTRL, 16'h0100);
    rc(DLA_ADR_MODE, 16'hFF80);
    sc(0, 16'h0014, 1'b0);
    sc(1, 16'h0014, 1'b0);
    sc(2, 16'h0014, 1'b1);
    report_and_stop();
  end
endmodule
